/* bench/spp_exec_assertions.sv */
module spp_chk (
  input wire logic          core_clk,
  input wire logic          rst,
  input wire logic          op_valid,
  input wire logic [7:0]    op_code,
  input wire logic          irq_stack_acc,
  input wire logic          nonmaskable_irq_request,
  input wire logic [15:0]   mem_rdata,
  input spp_pkg::spp_mem_req_t mem_req,
  input spp_pkg::spp_regs_t    regs,
  input wire logic          op_busy,
  input wire logic          op_done,
  input wire logic          op_illegal
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence take(logic [7:0] op);
    !op_busy && op_valid && !irq_stack_acc && op_code == op;
  endsequence
  sequence take_push;
    !op_busy && op_valid && !irq_stack_acc && !nonmaskable_irq_request &&
    op_code inside {8'h34, 8'h35, 8'h36, 8'h37, 8'h39, 8'h3b};
  endsequence
  sequence take_other;
    !op_busy && op_valid && !irq_stack_acc && !(op_code inside {8'h32,
    8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3a, 8'h3b});
  endsequence
  sequence push_end;
    mem_req.valid && mem_req.write ##1 op_done && !op_busy;
  endsequence
  AST_PUSH_ONE: assert property (take(8'h36) |=>
    mem_req.addr == $past(regs.sp) - 16'h0001
    && mem_req.wdata[15:8] == $past(regs.acc_a)) else $error("push a bad");
  AST_PUSH_TIME: assert property (!op_busy && op_valid &&
    !irq_stack_acc && op_code inside {8'h34, 8'h35, 8'h36, 8'h37, 8'h39,
    8'h3b} |=> push_end) else $error("push timing bad");
  AST_PUSH_D: assert property (take(8'h3b) |=> mem_req.wide &&
    mem_req.addr == $past(regs.sp) - 16'h0002 &&
    mem_req.wdata == {$past(regs.acc_a), $past(regs.acc_b)})
    else $error("push d bad");
  AST_PUSH_X: assert property (take(8'h34) |=> mem_req.wide &&
    mem_req.wdata == $past(regs.idx_x)) else $error("push x bad");
  AST_IRQ: assert property (!op_busy && irq_stack_acc |=>
    mem_req.write && mem_req.addr == $past(regs.sp) - 16'h0002 &&
    mem_req.wdata == {$past(regs.acc_b), $past(regs.acc_a)})
    else $error("irq stack bad");
  AST_PULL_A: assert property (take(8'h32) |=>
    !mem_req.write && mem_req.addr == $past(regs.sp) ##2
    regs.acc_a == $past(mem_rdata[15:8], 2) && op_done &&
    regs.sp == $past(regs.sp, 3) + 16'h0001) else $error("pull a bad");
  AST_PULL_D: assert property (take(8'h3a) |=> ##2
    {regs.acc_a, regs.acc_b} == $past(mem_rdata, 2) &&
    regs.sp == $past(regs.sp, 3) + 16'h0002) else $error("pull d bad");
  AST_XMASK: assert property (
    $rose(regs.condition_code_register[6]) && !$past(rst) |-> $past(nonmaskable_irq_request))
    else $error("x mask set");
  AST_PUSH_B: assert property (take(8'h37) |=>
    mem_req.addr == $past(regs.sp) - 16'h0001
    && mem_req.wdata[15:8] == $past(regs.acc_b)) else $error("push b bad");
  AST_PUSH_C: assert property (take(8'h39) |=>
    mem_req.addr == $past(regs.sp) - 16'h0001
    && mem_req.wdata[15:8] == $past(regs.condition_code_register)) else $error("push cc bad");
  AST_PUSH_Y: assert property (take(8'h35) |=> mem_req.wide &&
    mem_req.addr == $past(regs.sp) - 16'h0002 &&
    mem_req.wdata == $past(regs.idx_y)) else $error("push y bad");
  AST_PULL_B: assert property (take(8'h33) |=> ##2
    regs.acc_b == $past(mem_rdata[15:8], 2) && op_done &&
    regs.sp == $past(regs.sp, 3) + 16'h0001) else $error("pull b bad");
  AST_PULL_CC: assert property (take(8'h38) |=> ##1
    (regs.condition_code_register & 8'hbf) == ($past(mem_rdata[15:8]) & 8'hbf) &&
    regs.sp == $past(regs.sp, 2) + 16'h0001) else $error("pull cc bad");
  AST_PULL_CLR: assert property (take(8'h38) ##1
    !mem_rdata[14] && !nonmaskable_irq_request |=> !regs.condition_code_register[6])
    else $error("x mask kept");
  AST_KEEP_CC: assert property (
    take_push ##1 !nonmaskable_irq_request |=>
    regs.condition_code_register == $past(regs.condition_code_register, 2)) else $error("flags changed by push");
  AST_ILLEGAL: assert property (take_other |=> op_illegal && !op_busy &&
    !mem_req.valid) else $error("bad opcode not refused");
endmodule : spp_chk
bind spp_exec spp_chk i_chk (.core_clk, .rst, .op_valid, .op_code,
  .irq_stack_acc, .nonmaskable_irq_request, .mem_rdata, .mem_req, .regs,
  .op_busy, .op_done, .op_illegal);

/* bench/spp_exec_bench.sv */
module spp_exec_bench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    logic [7:0] op, a, b, cc, wb, cy;
    logic [15:0] sp, wa;
  } spp_row_t;
  logic core_clk, rst, op_valid, irq_stack_acc, nonmaskable_irq_request;
  logic op_busy, op_done, op_illegal;
  logic [7:0] op_code;
  logic [15:0] mem_rdata;
  spp_pkg::spp_mem_req_t mem_req;
  spp_pkg::spp_regs_t    regs;
  int n_errors, compares, cyc;
  logic [15:0] lat;
  spp_row_t rows [10] = '{
    '{8'h32, 8'h5a, 8'h00, 8'hd0, 8'h5a, 8'h02, 16'h0001, 16'h0000},
    '{8'h33, 8'h5a, 8'hc3, 8'hd0, 8'hc3, 8'h02, 16'h0002, 16'h0001},
    '{8'h3a, 8'h12, 8'h34, 8'hd0, 8'h12, 8'h02, 16'h0004, 16'h0002},
    '{8'h38, 8'h12, 8'h34, 8'h05, 8'h05, 8'h02, 16'h0005, 16'h0004},
    '{8'h36, 8'h12, 8'h34, 8'h05, 8'h12, 8'h01, 16'h0004, 16'h0004},
    '{8'h37, 8'h12, 8'h34, 8'h05, 8'h34, 8'h01, 16'h0003, 16'h0003},
    '{8'h39, 8'h12, 8'h34, 8'h05, 8'h05, 8'h01, 16'h0002, 16'h0002},
    '{8'h3b, 8'h12, 8'h34, 8'h05, 8'h12, 8'h01, 16'h0000, 16'h0000},
    '{8'h34, 8'h12, 8'h34, 8'h05, 8'h00, 8'h01, 16'hfffe, 16'hfffe},
    '{8'h35, 8'h12, 8'h34, 8'h05, 8'h00, 8'h01, 16'hfffc, 16'hfffc}};
  spp_exec i_spp_exec (.core_clk, .rst, .op_valid, .op_code, .irq_stack_acc,
    .nonmaskable_irq_request, .mem_rdata, .mem_req, .regs, .op_busy,
    .op_done, .op_illegal);
  spp_mem_model i_spp_mem_model (.core_clk, .mem_req, .mem_rdata);
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task run(input logic irq, input logic [7:0] op);
    @(posedge core_clk) #1;
    op_valid = !irq;
    irq_stack_acc = irq;
    op_code = op;
    @(posedge core_clk) #1;
    op_valid = 0;
    irq_stack_acc = 0;
    lat = 16'h0000;
    while (op_done !== 1'b1 && lat < 16'h0008) begin
      @(posedge core_clk) #1;
      lat++;
    end
  endtask : run
  task close_out;
    $display("n_errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  initial begin
    core_clk = 0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Hang guard: the whole sequence needs well under 200 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    {rst, op_valid, op_code, irq_stack_acc, nonmaskable_irq_request} = '1;
    {op_valid, op_code, irq_stack_acc, nonmaskable_irq_request} = '0;
    {i_spp_mem_model.mem[0], i_spp_mem_model.mem[1]} = 16'h5ac3;
    {i_spp_mem_model.mem[2], i_spp_mem_model.mem[3]} = 16'h1234;
    i_spp_mem_model.mem[4] = 8'h05;
    i_spp_mem_model.mem[16'hfffc] = 8'hff;
    i_spp_mem_model.mem[16'hfffe] = 8'hff;
    repeat (4) @(posedge core_clk);
    #1 rst = 0;
    chk(regs.condition_code_register, 8'hd0);
    foreach (rows[k]) begin
      run(1'b0, rows[k].op);
      chk(regs.sp, rows[k].sp);
      chk({regs.acc_a, regs.acc_b}, {rows[k].a, rows[k].b});
      chk(regs.condition_code_register, rows[k].cc);
      chk(i_spp_mem_model.mem[rows[k].wa], rows[k].wb);
      chk(lat, rows[k].cy);
      chk(op_busy, 1'b0);
    end
    i_spp_mem_model.mem[16'hfffc] = 8'hff;
    run(1'b0, 8'h38);
    chk(regs.condition_code_register, 8'hbf);
    nonmaskable_irq_request = 1;
    @(posedge core_clk) #1 nonmaskable_irq_request = 0;
    chk(regs.condition_code_register, 8'hff);
    run(1'b1, 8'h00);
    chk(regs.sp, 16'hfffb);
    chk(i_spp_mem_model.mem[16'hfffb], 8'h34);
    chk(i_spp_mem_model.mem[16'hfffc], 8'h12);
    chk(lat, 16'h0001);
    @(posedge core_clk) #1 op_valid = 1;
    @(posedge core_clk) #1 op_valid = 0;
    chk(op_illegal, 1'b1);
    chk(regs.sp, 16'hfffb);
    rst = 1;
    repeat (4) @(posedge core_clk);
    #1 rst = 0;
    chk(regs.sp, 16'h0000);
    chk(regs.condition_code_register, 8'hd0);
    close_out();
  end
endmodule : spp_exec_bench

/* bench/spp_mem_model.sv */
module spp_mem_model (
  input wire logic             core_clk,
  input spp_pkg::spp_mem_req_t mem_req,
  output logic [15:0]          mem_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  mem [0:65535];
  logic [15:0] idle_ff = 16'h0f0f;
  // Read data stands in the cycle of the request, since the core takes it
  // on the edge that closes that cycle; outside a read answer the bus
  // shows a toggling word so stale data never looks valid
  assign mem_rdata = (mem_req.valid && !mem_req.write) ?
                     {mem[mem_req.addr], mem[mem_req.addr + 16'h0001]} :
                     idle_ff;
  always @(posedge core_clk) begin
    if (mem_req.valid && mem_req.write) begin
      mem[mem_req.addr] <= mem_req.wdata[15:8];
      if (mem_req.wide)
        mem[mem_req.addr + 16'h0001] <= mem_req.wdata[7:0];
    end
    idle_ff <= ~idle_ff;
  end
endmodule : spp_mem_model

/* inc/spp_pkg.sv */
package spp_pkg;

  // Opcodes handled by this unit
  localparam logic [7:0] OP_PUSH_FIRST_ACC  = 8'h36;
  localparam logic [7:0] OP_PUSH_SECOND_ACC = 8'h37;
  localparam logic [7:0] OP_PUSH_FLAGS      = 8'h39;
  localparam logic [7:0] OP_PUSH_DOUBLE_ACC = 8'h3b;
  localparam logic [7:0] OP_PUSH_INDEX_ONE  = 8'h34;
  localparam logic [7:0] OP_PUSH_INDEX_TWO  = 8'h35;
  localparam logic [7:0] OP_PULL_FIRST_ACC  = 8'h32;
  localparam logic [7:0] OP_PULL_SECOND_ACC = 8'h33;
  localparam logic [7:0] OP_PULL_FLAGS      = 8'h38;
  localparam logic [7:0] OP_PULL_DOUBLE_ACC = 8'h3a;

  // Flag positions in the condition code register
  localparam int unsigned CC_XMASK_BIT = 6;
  localparam int unsigned CC_IMASK_BIT = 4;

  // Reset values and stack pointer steps
  localparam logic [7:0]  CC_RESET    = 8'hd0;
  localparam logic [15:0] SP_RESET    = 16'h0000;
  localparam logic [15:0] SP_STEP_ONE = 16'h0001;
  localparam logic [15:0] SP_STEP_TWO = 16'h0002;

  typedef enum logic [1:0] {
    SPP_IDLE,
    SPP_WRITE,
    SPP_READ,
    SPP_FREE
  } spp_state_t;

  // Architectural registers this unit reads and updates
  typedef struct packed {
    logic [7:0]  acc_a;
    logic [7:0]  acc_b;
    logic [15:0] idx_x;
    logic [15:0] idx_y;
    logic [15:0] sp;
    logic [7:0]  condition_code_register;
  } spp_regs_t;

  // One memory cycle towards the stack
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        wide;
    logic [15:0] addr;
    logic [15:0] wdata;
  } spp_mem_req_t;

endpackage : spp_pkg

/* src/spp_exec.sv */
module spp_exec (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  // Instruction issue
  input  wire logic                  op_valid,
  input  wire logic [7:0]            op_code,
  // Interrupt stacking of the accumulators and the mask set
  input  wire logic                  irq_stack_acc,
  input  wire logic                  nonmaskable_irq_request,
  // Stack memory
  input  wire logic [15:0]           mem_rdata,
  // Outputs
  output spp_pkg::spp_mem_req_t      mem_req,
  output spp_pkg::spp_regs_t         regs,
  output logic                       op_busy,
  output logic                       op_done,
  output logic                       op_illegal
);

  typedef struct packed {
    spp_pkg::spp_state_t   state;
    logic [7:0]            op;
    spp_pkg::spp_regs_t    regs;
    spp_pkg::spp_mem_req_t req;
    logic                  busy;
    logic                  done;
    logic                  illegal;
  } spp_core_t;

  spp_core_t cur_ff;
  spp_core_t nxt_cur;
  // Memory answers a read inside the cycle in which the request stands;
  // the word is taken on the edge that closes that cycle. A slow memory
  // would need a wait input, which this unit does not have.

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [15:0] sp_m1;
    logic [15:0] sp_m2;
    logic [7:0]  pulled;
    sp_m1       = cur_ff.regs.sp - spp_pkg::SP_STEP_ONE;
    sp_m2       = cur_ff.regs.sp - spp_pkg::SP_STEP_TWO;
    pulled      = mem_rdata[15:8];
    // Anything not assigned below holds, the flags included
    nxt_cur     = cur_ff;
    nxt_cur.req = '0;
    nxt_cur.done    = 1'b0;
    nxt_cur.illegal = 1'b0;
    case (cur_ff.state)
      spp_pkg::SPP_IDLE: begin
        if (irq_stack_acc) begin
          // Interrupt order: B low, A high, the reverse of a double push
          // The rest of the interrupt frame is stacked outside this unit
          nxt_cur.regs.sp    = sp_m2;
          nxt_cur.req.valid  = 1'b1;
          nxt_cur.req.write  = 1'b1;
          nxt_cur.req.wide   = 1'b1;
          nxt_cur.req.addr   = sp_m2;
          nxt_cur.req.wdata  = {cur_ff.regs.acc_b, cur_ff.regs.acc_a};
          nxt_cur.state      = spp_pkg::SPP_WRITE;
          nxt_cur.busy       = 1'b1;
        end else if (op_valid) begin
          nxt_cur.op   = op_code;
          nxt_cur.busy = 1'b1;
          nxt_cur.req.valid = 1'b1;
          case (op_code)
            spp_pkg::OP_PUSH_FIRST_ACC: begin
              nxt_cur.regs.sp   = sp_m1;
              nxt_cur.req.write = 1'b1;
              nxt_cur.req.addr  = sp_m1;
              nxt_cur.req.wdata = {cur_ff.regs.acc_a, 8'h00};
              nxt_cur.state     = spp_pkg::SPP_WRITE;
            end
            spp_pkg::OP_PUSH_SECOND_ACC: begin
              nxt_cur.regs.sp   = sp_m1;
              nxt_cur.req.write = 1'b1;
              nxt_cur.req.addr  = sp_m1;
              nxt_cur.req.wdata = {cur_ff.regs.acc_b, 8'h00};
              nxt_cur.state     = spp_pkg::SPP_WRITE;
            end
            spp_pkg::OP_PUSH_FLAGS: begin
              nxt_cur.regs.sp   = sp_m1;
              nxt_cur.req.write = 1'b1;
              nxt_cur.req.addr  = sp_m1;
              nxt_cur.req.wdata = {cur_ff.regs.condition_code_register, 8'h00};
              nxt_cur.state     = spp_pkg::SPP_WRITE;
            end
            spp_pkg::OP_PUSH_DOUBLE_ACC: begin
              nxt_cur.regs.sp   = sp_m2;
              nxt_cur.req.write = 1'b1;
              nxt_cur.req.wide  = 1'b1;
              nxt_cur.req.addr  = sp_m2;
              nxt_cur.req.wdata = {cur_ff.regs.acc_a, cur_ff.regs.acc_b};
              nxt_cur.state     = spp_pkg::SPP_WRITE;
            end
            spp_pkg::OP_PUSH_INDEX_ONE: begin
              nxt_cur.regs.sp   = sp_m2;
              nxt_cur.req.write = 1'b1;
              nxt_cur.req.wide  = 1'b1;
              nxt_cur.req.addr  = sp_m2;
              nxt_cur.req.wdata = cur_ff.regs.idx_x;
              nxt_cur.state     = spp_pkg::SPP_WRITE;
            end
            spp_pkg::OP_PUSH_INDEX_TWO: begin
              nxt_cur.regs.sp   = sp_m2;
              nxt_cur.req.write = 1'b1;
              nxt_cur.req.wide  = 1'b1;
              nxt_cur.req.addr  = sp_m2;
              nxt_cur.req.wdata = cur_ff.regs.idx_y;
              nxt_cur.state     = spp_pkg::SPP_WRITE;
            end
            spp_pkg::OP_PULL_FIRST_ACC,
            spp_pkg::OP_PULL_SECOND_ACC,
            spp_pkg::OP_PULL_FLAGS: begin
              // Pointer moves only after the data is back
              nxt_cur.req.addr = cur_ff.regs.sp;
              nxt_cur.state    = spp_pkg::SPP_READ;
            end
            spp_pkg::OP_PULL_DOUBLE_ACC: begin
              nxt_cur.req.wide = 1'b1;
              nxt_cur.req.addr = cur_ff.regs.sp;
              nxt_cur.state    = spp_pkg::SPP_READ;
            end
            default: begin
              nxt_cur.req.valid = 1'b0;
              nxt_cur.busy      = 1'b0;
              nxt_cur.illegal   = 1'b1;
            end
          endcase
        end
      end
      spp_pkg::SPP_WRITE: begin
        // Write cycle closes; the next cycle is the opcode fetch
        nxt_cur.state = spp_pkg::SPP_IDLE;
        nxt_cur.busy  = 1'b0;
        nxt_cur.done  = 1'b1;
      end
      spp_pkg::SPP_READ: begin
        // Read data lands here; flags are untouched except by the flags pull
        case (cur_ff.op)
          spp_pkg::OP_PULL_FIRST_ACC: begin
            nxt_cur.regs.acc_a = pulled;
            nxt_cur.regs.sp    = cur_ff.regs.sp + spp_pkg::SP_STEP_ONE;
          end
          spp_pkg::OP_PULL_SECOND_ACC: begin
            nxt_cur.regs.acc_b = pulled;
            nxt_cur.regs.sp    = cur_ff.regs.sp + spp_pkg::SP_STEP_ONE;
          end
          spp_pkg::OP_PULL_FLAGS: begin
            nxt_cur.regs.condition_code_register = pulled;
            // Mask may only stay or drop; a pull can never raise it
            nxt_cur.regs.condition_code_register[spp_pkg::CC_XMASK_BIT] =
              pulled[spp_pkg::CC_XMASK_BIT] &
              cur_ff.regs.condition_code_register[spp_pkg::CC_XMASK_BIT];
            nxt_cur.regs.sp  = cur_ff.regs.sp + spp_pkg::SP_STEP_ONE;
          end
          spp_pkg::OP_PULL_DOUBLE_ACC: begin
            // A from the lower address, B from the upper
            nxt_cur.regs.acc_a = mem_rdata[15:8];
            nxt_cur.regs.acc_b = mem_rdata[7:0];
            nxt_cur.regs.sp    = cur_ff.regs.sp + spp_pkg::SP_STEP_TWO;
          end
          default: begin
            nxt_cur.regs = cur_ff.regs;
          end
        endcase
        nxt_cur.state = spp_pkg::SPP_FREE;
      end
      spp_pkg::SPP_FREE: begin
        nxt_cur.state = spp_pkg::SPP_IDLE;
        nxt_cur.busy  = 1'b0;
        nxt_cur.done  = 1'b1;
      end
      default: begin
        nxt_cur.state = spp_pkg::SPP_IDLE;
      end
    endcase
    // Only the non-maskable request, never an instruction, raises the mask
    // Placed last so it wins over a flags pull clearing the mask
    if (nonmaskable_irq_request) begin
      nxt_cur.regs.condition_code_register[spp_pkg::CC_XMASK_BIT] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (rst) begin
      // Index registers have no load path here and stay at zero
      cur_ff          <= '0;
      cur_ff.state    <= spp_pkg::SPP_IDLE;
      cur_ff.regs.sp  <= spp_pkg::SP_RESET;
      cur_ff.regs.condition_code_register <= spp_pkg::CC_RESET;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // Every output is a register bit; no input reaches an output directly
  assign mem_req    = cur_ff.req;
  assign regs       = cur_ff.regs;
  assign op_busy    = cur_ff.busy;
  assign op_done    = cur_ff.done;
  assign op_illegal = cur_ff.illegal;

endmodule : spp_exec
